// >>> i2c_fast_scl_defines.svh
// Constants for the fast-mode SCL period count block
//
// How it works
// R01: The high-period count is a 16-bit value in bits 15..0 setting SCL high cycles in fast mode.
// R02: A separate 16-bit low-period count sets SCL low cycles in fast mode.
// R03: In high-speed mode the fast counts time the master code and start byte or general call.
// R04: Software programs both counts before starting any bus transfer.
// R05: Writes to either count are taken only while enable bit 0 of the enable register is clear.
// R06: A high-period value below 6 is stored as 6.
// R07: A low-period value below 8 is stored as 8.
// R08: Upper sixteen bits of both count registers read as zero and ignore writes.
`ifndef I2C_FAST_SCL_DEFINES_SVH
`define I2C_FAST_SCL_DEFINES_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define ENABLE_REG_OFS    8'h6c
`define FAST_HIGH_OFS     8'h1c
`define FAST_LOW_OFS      8'h20
`define PHASE_STATUS_OFS  8'h70

// ----------------------------------------------------------------
// Fields, reset values and minimums
// ----------------------------------------------------------------
`define ENABLE_BIT        0
`define HS_MODE_BIT       1
`define COUNT_RESET       16'h0000
`define FAST_HIGH_MIN     16'h0006
`define FAST_LOW_MIN      16'h0008

`endif

// >>> i2c_fast_scl_pkg.sv
// Types for the fast-mode SCL period count block
package i2c_fast_scl_pkg;
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_HIGH = 2'b01,
    PH_LOW  = 2'b10
  } phase_type;
endpackage

// >>> i2c_fast_scl_period_counts.sv
// Fast-mode SCL high/low period counts with Wishbone registers and link-side timer
`timescale 1ns/10ps
`include "i2c_fast_scl_defines.svh"

module i2c_fast_scl_period_counts (
  // System clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // Wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // Link domain
  input  wire logic        link_clk,
  input  wire logic        link_rst,
  input  wire logic        fast_phase_req,
  output logic             scl_high_o,
  output logic             hs_prefix_o,
  // Stored counts toward the waveform logic
  output logic      [15:0] fast_high_count,
  output logic      [15:0] fast_low_count
);

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic        req;
  logic        wr;
  logic        enable_q;
  logic        hs_mode_q;
  logic [15:0] high_q;
  logic [15:0] low_q;
  logic [15:0] wdata16;

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  sel);
    merge16 = {sel[1] ? nw[15:8] : old[15:8], sel[0] ? nw[7:0] : old[7:0]};
  endfunction

  function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] lo);
    clamp16 = (v < lo) ? lo : v;
  endfunction

  assign req = cyc_i && stb_i && !ack_o;
  // Writes land on the edge at which the master sees ack
  assign wr  = cyc_i && stb_i && we_i && ack_o;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= req;
    end
  end

  // ----------------------------------------------------------------
  // Enable register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      enable_q  <= 1'b0;
      hs_mode_q <= 1'b0;
    end else if (wr && adr_i == `ENABLE_REG_OFS && sel_i[0]) begin
      enable_q  <= dat_i[`ENABLE_BIT];
      hs_mode_q <= dat_i[`HS_MODE_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Count registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      high_q <= `COUNT_RESET;
    end else if (wr && adr_i == `FAST_HIGH_OFS && !enable_q) begin // [R05]
      high_q <= clamp16(merge16(high_q, dat_i, sel_i), `FAST_HIGH_MIN); // [R01] [R06] [R08]
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      low_q <= `COUNT_RESET;
    end else if (wr && adr_i == `FAST_LOW_OFS && !enable_q) begin // [R05]
      low_q <= clamp16(merge16(low_q, dat_i, sel_i), `FAST_LOW_MIN); // [R02] [R07] [R08]
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      fast_high_count <= `COUNT_RESET;
      fast_low_count  <= `COUNT_RESET;
    end else begin
      fast_high_count <= high_q;
      fast_low_count  <= low_q;
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [1:0] phase_seen_q;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      dat_o <= 32'h0000_0000;
    end else if (req && !we_i) begin
      case (adr_i)
        `ENABLE_REG_OFS:   dat_o <= {30'h0000_0000, hs_mode_q, enable_q};
        `FAST_HIGH_OFS:    dat_o <= {16'h0000, high_q}; // [R08]
        `FAST_LOW_OFS:     dat_o <= {16'h0000, low_q};  // [R08]
        `PHASE_STATUS_OFS: dat_o <= {30'h0000_0000, phase_seen_q};
        default:           dat_o <= 32'h0000_0000;
      endcase
    end else begin
      dat_o <= 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Crossing to link domain
  // ----------------------------------------------------------------
  // Third enable stage marks when the link-side count copies are loaded
  logic [2:0] en_sync_q;
  logic [1:0] hs_sync_q;
  logic [1:0] req_sync_q;

  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      en_sync_q  <= 3'b000;
      hs_sync_q  <= 2'b00;
      req_sync_q <= 2'b00;
    end else begin
      en_sync_q  <= {en_sync_q[1:0], enable_q};
      hs_sync_q  <= {hs_sync_q[0], hs_mode_q};
      req_sync_q <= {req_sync_q[0], fast_phase_req};
    end
  end

  // ----------------------------------------------------------------
  // Link-side copies of the counts
  // ----------------------------------------------------------------
  // Counts are frozen while enabled; copy once the synced enable rises
  logic [15:0] link_high_q;
  logic [15:0] link_low_q;

  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      link_high_q <= `COUNT_RESET;
      link_low_q  <= `COUNT_RESET;
    end else if (en_sync_q[1] && !en_sync_q[2]) begin
      link_high_q <= high_q; // [R01] [R05]
      link_low_q  <= low_q;  // [R02] [R05]
    end
  end

  // ----------------------------------------------------------------
  // Link-side SCL phase timer
  // ----------------------------------------------------------------
  i2c_fast_scl_pkg::phase_type phase_q;
  logic [15:0]                 cnt_q;
  logic                        busy_q;

  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      phase_q <= i2c_fast_scl_pkg::PH_IDLE;
      cnt_q   <= 16'h0000;
    end else begin
      case (phase_q)
        i2c_fast_scl_pkg::PH_IDLE: begin
          if (en_sync_q[2] && req_sync_q[1]) begin
            phase_q <= i2c_fast_scl_pkg::PH_LOW;
            cnt_q   <= link_low_q - 16'h0001; // [R02]
          end
        end
        i2c_fast_scl_pkg::PH_LOW: begin
          if (cnt_q != 16'h0000) begin
            cnt_q <= cnt_q - 16'h0001;
          end else begin
            phase_q <= i2c_fast_scl_pkg::PH_HIGH;
            cnt_q   <= link_high_q - 16'h0001; // [R01]
          end
        end
        i2c_fast_scl_pkg::PH_HIGH: begin
          if (cnt_q != 16'h0000) begin
            cnt_q <= cnt_q - 16'h0001;
          end else if (en_sync_q[2] && req_sync_q[1]) begin
            phase_q <= i2c_fast_scl_pkg::PH_LOW;
            cnt_q   <= link_low_q - 16'h0001; // [R02]
          end else begin
            phase_q <= i2c_fast_scl_pkg::PH_IDLE;
          end
        end
        default: begin
          phase_q <= i2c_fast_scl_pkg::PH_IDLE;
          cnt_q   <= 16'h0000;
        end
      endcase
    end
  end

  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      scl_high_o  <= 1'b1;
      hs_prefix_o <= 1'b0;
      busy_q      <= 1'b0;
    end else begin
      scl_high_o  <= (phase_q != i2c_fast_scl_pkg::PH_LOW);
      busy_q      <= (phase_q != i2c_fast_scl_pkg::PH_IDLE);
      hs_prefix_o <= hs_sync_q[1] && (phase_q != i2c_fast_scl_pkg::PH_IDLE); // [R03]
    end
  end

  // Phase back to system domain as status
  logic [1:0] ph_sync_q;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ph_sync_q    <= 2'b00;
      phase_seen_q <= 2'b00;
    end else begin
      ph_sync_q    <= {ph_sync_q[0], busy_q};
      phase_seen_q <= {hs_mode_q, ph_sync_q[1]};
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_high_locked;
    @(posedge sys_clk) disable iff (rst)
      enable_q |=> $stable(high_q);
  endproperty
  a_high_locked: assert property (p_high_locked) else $error("high count changed while enabled"); // [R05]

  property p_low_locked;
    @(posedge sys_clk) disable iff (rst)
      enable_q |=> $stable(low_q);
  endproperty
  a_low_locked: assert property (p_low_locked) else $error("low count changed while enabled"); // [R05]

  property p_high_min;
    @(posedge sys_clk) disable iff (rst)
      (wr && adr_i == `FAST_HIGH_OFS && !enable_q && sel_i[1:0] == 2'b11 && dat_i[15:0] < 16'h0006)
      |=> high_q == 16'h0006;
  endproperty
  a_high_min: assert property (p_high_min) else $error("high count not clamped to 6"); // [R06]

  property p_low_min;
    @(posedge sys_clk) disable iff (rst)
      (wr && adr_i == `FAST_LOW_OFS && !enable_q && sel_i[1:0] == 2'b11 && dat_i[15:0] < 16'h0008)
      |=> low_q == 16'h0008;
  endproperty
  a_low_min: assert property (p_low_min) else $error("low count not clamped to 8"); // [R07]

  property p_high_store;
    @(posedge sys_clk) disable iff (rst)
      (wr && adr_i == `FAST_HIGH_OFS && !enable_q && sel_i[1:0] == 2'b11 && dat_i[15:0] >= 16'h0006)
      |=> high_q == $past(dat_i[15:0]);
  endproperty
  a_high_store: assert property (p_high_store) else $error("high count not stored"); // [R01]

  property p_low_store;
    @(posedge sys_clk) disable iff (rst)
      (wr && adr_i == `FAST_LOW_OFS && !enable_q && sel_i[1:0] == 2'b11 && dat_i[15:0] >= 16'h0008)
      |=> low_q == $past(dat_i[15:0]);
  endproperty
  a_low_store: assert property (p_low_store) else $error("low count not stored"); // [R02]

  sequence s_count_read;
    req && !we_i && (adr_i == `FAST_HIGH_OFS || adr_i == `FAST_LOW_OFS);
  endsequence

  property p_upper_zero;
    @(posedge sys_clk) disable iff (rst)
      s_count_read |=> ack_o && dat_o[31:16] == 16'h0000;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("reserved bits not zero"); // [R08]

  property p_hs_prefix;
    @(posedge link_clk) disable iff (link_rst)
      hs_prefix_o |-> hs_sync_q[1] || $past(hs_sync_q[1]);
  endproperty
  a_hs_prefix: assert property (p_hs_prefix) else $error("prefix flag without hs mode"); // [R03]

  property p_high_port;
    @(posedge sys_clk) disable iff (rst)
      fast_high_count == $past(high_q);
  endproperty
  a_high_port: assert property (p_high_port) else $error("high count port wrong"); // [R01]

  property p_low_port;
    @(posedge sys_clk) disable iff (rst)
      fast_low_count == $past(low_q);
  endproperty
  a_low_port: assert property (p_low_port) else $error("low count port wrong"); // [R02]

  property p_high_floor;
    @(posedge sys_clk) disable iff (rst)
      (!$past(rst) && $changed(high_q)) |-> high_q >= `FAST_HIGH_MIN;
  endproperty
  a_high_floor: assert property (p_high_floor) else $error("high count below minimum"); // [R06]

  property p_low_floor;
    @(posedge sys_clk) disable iff (rst)
      (!$past(rst) && $changed(low_q)) |-> low_q >= `FAST_LOW_MIN;
  endproperty
  a_low_floor: assert property (p_low_floor) else $error("low count below minimum"); // [R07]

  sequence s_start_seen;
    phase_q == i2c_fast_scl_pkg::PH_IDLE && en_sync_q[2] && req_sync_q[1];
  endsequence

  sequence s_high_repeat;
    phase_q == i2c_fast_scl_pkg::PH_HIGH && cnt_q == 16'h0000
      && en_sync_q[2] && req_sync_q[1];
  endsequence

  sequence s_low_done;
    phase_q == i2c_fast_scl_pkg::PH_LOW && cnt_q == 16'h0000;
  endsequence

  sequence s_low_loaded;
    phase_q == i2c_fast_scl_pkg::PH_LOW && cnt_q == $past(link_low_q) - 16'h0001;
  endsequence

  sequence s_high_loaded;
    phase_q == i2c_fast_scl_pkg::PH_HIGH && cnt_q == $past(link_high_q) - 16'h0001;
  endsequence

  property p_low_start;
    @(posedge link_clk) disable iff (link_rst)
      s_start_seen |=> s_low_loaded;
  endproperty
  a_low_start: assert property (p_low_start) else $error("low phase not started from count"); // [R02]

  property p_low_repeat;
    @(posedge link_clk) disable iff (link_rst)
      s_high_repeat |=> s_low_loaded;
  endproperty
  a_low_repeat: assert property (p_low_repeat) else $error("low phase not reloaded"); // [R02]

  property p_high_after_low;
    @(posedge link_clk) disable iff (link_rst)
      s_low_done |=> s_high_loaded;
  endproperty
  a_high_after_low: assert property (p_high_after_low) else $error("high phase not loaded"); // [R01]

  property p_copy_locked;
    @(posedge link_clk) disable iff (link_rst)
      en_sync_q[2] |=> $stable(link_high_q) && $stable(link_low_q);
  endproperty
  a_copy_locked: assert property (p_copy_locked) else $error("link count copy moved"); // [R05]

endmodule // i2c_fast_scl_period_counts

// >>> scl_phase_monitor.sv
// Link-side requester that measures the SCL low and high phase lengths
`timescale 1ns/10ps

module scl_phase_monitor (
  // Link clock and control from the bench
  input  wire logic        link_clk,
  input  wire logic        run,
  // Timer output from the block
  input  wire logic        scl_high_o,
  // Request toward the block and measured phases
  output logic             fast_phase_req,
  output logic      [15:0] low_len,
  output logic      [15:0] high_len
);
  logic        last_q;
  logic [15:0] run_len_q;

  always_ff @(posedge link_clk) begin
    fast_phase_req <= run;
  end

  // Length of each finished phase, in link cycles
  always_ff @(posedge link_clk) begin
    last_q <= scl_high_o;
    if (scl_high_o !== last_q) begin
      run_len_q <= 16'h0001;
      if (last_q === 1'b1) high_len <= run_len_q;
      if (last_q === 1'b0) low_len <= run_len_q;
    end else begin
      run_len_q <= run_len_q + 16'h0001;
    end
  end
endmodule // scl_phase_monitor

// >>> tb.sv
// Testbench for the fast-mode SCL period count block
`timescale 1ns/10ps

module tb;
  logic        sys_clk, rst, cyc_i, stb_i, we_i, link_clk, link_rst, run, req;
  logic        ack_o, scl_high_o, hs_prefix_o;
  logic [7:0]  adr_i;
  logic [3:0]  sel_i, lanes;
  logic [31:0] dat_i, dat_o, rd;
  logic [15:0] fast_high_count, fast_low_count, low_len, high_len;
  int          miscompares, comparisons, cycles;
  logic [7:0]  ta [8] = '{8'h1c, 8'h1c, 8'h1c, 8'h20, 8'h20, 8'h20, 8'h1c, 8'h20};
  logic [31:0] tw [8] = '{32'habcd0005, 32'h6, 32'hffff1234, 32'h5a5a0007, 32'h8,
                          32'h0000beef, 32'h7, 32'h9};
  logic [31:0] te [8] = '{32'h6, 32'h6, 32'h1234, 32'h8, 32'h8, 32'hbeef, 32'h7, 32'h9};

  i2c_fast_scl_period_counts DUT (.sys_clk(sys_clk), .rst(rst), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .link_clk(link_clk), .link_rst(link_rst),
    .fast_phase_req(req), .scl_high_o(scl_high_o), .hs_prefix_o(hs_prefix_o),
    .fast_high_count(fast_high_count), .fast_low_count(fast_low_count));

  scl_phase_monitor far_side (.link_clk(link_clk), .run(run), .scl_high_o(scl_high_o),
    .fast_phase_req(req), .low_len(low_len), .high_len(high_len));

  // ----------------------------------------------------------------
  // Clocks, link reset and timeout
  // ----------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever #24 link_clk = ~link_clk;
  end
  initial begin
    link_rst = 1'b1;
    repeat (3) @(posedge link_clk);
    link_rst <= 1'b0;
  end
  initial cycles = 0;
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      close_out();
    end
  end

  // ----------------------------------------------------------------
  // Bus and check tasks
  // ----------------------------------------------------------------
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] r);
    @(posedge sys_clk);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= lanes;
    do @(posedge sys_clk); while (ack_o !== 1'b1);
    r = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic close_out();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {cyc_i, stb_i, we_i, run} = 4'h0;
    adr_i = 8'h00;
    sel_i = 4'h0;
    lanes = 4'hf;
    dat_i = 32'h0;
    rst = 1'b1;
    miscompares = 0;
    comparisons = 0;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    wb(1'b0, 8'h1c, 32'h0, rd);
    chk("high reset", 32'h0, rd);
    wb(1'b0, 8'h20, 32'h0, rd);
    chk("low reset", 32'h0, rd);
    for (int i = 0; i < 8; i++) begin
      wb(1'b1, ta[i], tw[i], rd);
      wb(1'b0, ta[i], 32'h0, rd);
      chk("count", te[i], rd);
    end
    chk("high port", 32'h7, {16'h0, fast_high_count});
    chk("low port", 32'h9, {16'h0, fast_low_count});
    wb(1'b1, 8'h40, 32'hffffffff, rd);
    wb(1'b0, 8'h40, 32'h0, rd);
    chk("unmapped", 32'h0, rd);
    wb(1'b1, 8'h6c, 32'h3, rd);
    wb(1'b1, 8'h1c, 32'h100, rd);
    wb(1'b1, 8'h20, 32'h100, rd);
    wb(1'b0, 8'h1c, 32'h0, rd);
    chk("high locked", 32'h7, rd);
    wb(1'b0, 8'h20, 32'h0, rd);
    chk("low locked", 32'h9, rd);
    @(posedge sys_clk);
    run <= 1'b1;
    repeat (90) @(posedge link_clk);
    chk("hs prefix", 32'h1, {31'h0, hs_prefix_o});
    chk("low phase", 32'h9, {16'h0, low_len});
    chk("high phase", 32'h7, {16'h0, high_len});
    wb(1'b0, 8'h70, 32'h0, rd);
    chk("status hs busy", 32'h3, rd);
    @(posedge sys_clk);
    run <= 1'b0;
    wb(1'b1, 8'h6c, 32'h0, rd);
    lanes = 4'h2;
    wb(1'b1, 8'h1c, 32'hffff12aa, rd);
    lanes = 4'h1;
    wb(1'b1, 8'h20, 32'hffffff03, rd);
    lanes = 4'hf;
    wb(1'b0, 8'h1c, 32'h0, rd);
    chk("high lane merge", 32'h1207, rd);
    wb(1'b0, 8'h20, 32'h0, rd);
    chk("low lane clamp", 32'h8, rd);
    wb(1'b1, 8'h1c, 32'h6, rd);
    wb(1'b1, 8'h20, 32'h8, rd);
    wb(1'b1, 8'h6c, 32'h1, rd);
    @(posedge sys_clk);
    run <= 1'b1;
    repeat (60) @(posedge link_clk);
    chk("hs prefix off", 32'h0, {31'h0, hs_prefix_o});
    chk("low phase min", 32'h8, {16'h0, low_len});
    chk("high phase min", 32'h6, {16'h0, high_len});
    wb(1'b0, 8'h70, 32'h0, rd);
    chk("status busy", 32'h1, rd);
    @(posedge sys_clk);
    run <= 1'b0;
    wb(1'b1, 8'h6c, 32'h0, rd);
    close_out();
  end
endmodule // tb
